// ==== design/hbp_device.sv ====
/*
  Device end of the parallel host bus port: strobe decode, address latch,
  small register file, DMA requests, interrupt output, reset indication.
  Assumes all pins synchronous to CORE_CLK; shared wires resolved outside.
*/
// Summary of operation
// RL1 - Registers respond only while chip select low
// RL2 - Data direction from select, strobes, mode
// RL3 - Multiplexed mode: address then data on lines
// RL4 - Latch transparent while ALE high, holds after
// RL5 - ALE level picks multiplexed or demultiplexed
// RL6 - Mode input picks strobe convention
// RL7 - Separate strobes mark write or read
// RL8 - Data strobe: direction line gives direction
// RL9 - Seven-bit address, bit 4 shared pin
// RL10 - DMA mode forces address bit 4 zero
// RL11 - Receive DMA request, polarity, low after reset
// RL12 - Transmit DMA request, polarity, low after reset
// RL13 - Interrupt push-pull or open drain, Z at reset
// RL14 - Interrupt asserts on service need
// RL15 - Reset indication held 500 us after reset
// RL16 - Deselected: data Z, strobes ignored
`timescale 1ns/1ps
`default_nettype none
module hbp_device #(
  parameter int RESET_HOLD = hbp_pkg::RESET_HOLD_CYC
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  hbp_if.dev BUS,
  input wire logic [7:0] USER_EVENT_SET,
  output logic [7:0] USER_CFG,
  output logic [7:0] USER_SCRATCH
);
  import hbp_pkg::*;

  // ****************************************************************
  // Reset indication
  // ****************************************************************
  logic [31:0] rst_cnt_reg;
  logic in_reset_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_cnt_reg <= 32'h0;
      in_reset_reg <= 1'b1;
    end else if (in_reset_reg) begin
      if (rst_cnt_reg >= 32'(RESET_HOLD - 1))
        in_reset_reg <= 1'b0; // [RL15]
      else
        rst_cnt_reg <= rst_cnt_reg + 32'h1;
    end
  end
  assign BUS.reset_indication = in_reset_reg; // [RL15]

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic mux_mode;
  logic sel;
  logic rd_act;
  logic wr_act;
  logic [6:0] addr_raw;
  logic [6:0] addr_eff;
  logic [6:0] addr_lat_reg;
  logic [7:0] cfg_reg;
  logic dma_mode;

  assign dma_mode = cfg_reg[CFG_DMA_EN];
  assign sel = !BUS.cs_n && !in_reset_reg; // [RL1] [RL16]
  assign mux_mode = !BUS.ale; // [RL5]
  // Direction mode: rd_ds_n is data strobe, wr_rw high = read [RL6]
  assign rd_act = sel && !BUS.rd_ds_n && (BUS.mode ? BUS.wr_rw : 1'b1); // [RL7] [RL8]
  assign wr_act = sel && (BUS.mode ? (!BUS.rd_ds_n && !BUS.wr_rw)
                                   : (!BUS.wr_rw && BUS.rd_ds_n)); // [RL7] [RL8]

  // Multiplexed mode latches the address pins, not the data lines, while ALE is high
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      addr_lat_reg <= 7'h00;
    else if (BUS.ale)
      addr_lat_reg <= {BUS.addr[6:5], BUS.dma_ack_in, BUS.addr[3:0]}; // [RL4]
  end

  // Latch is transparent while ALE is high, so demux uses the pins
  assign addr_raw = mux_mode ? addr_lat_reg // [RL3] [RL4]
                             : {BUS.addr[6:5], BUS.dma_ack_in, BUS.addr[3:0]}; // [RL9]
  assign addr_eff = {addr_raw[6:5], addr_raw[4] & !dma_mode, addr_raw[3:0]}; // [RL10]

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic wr_act_d_reg;
  logic wr_pulse;
  logic [7:0] event_reg;
  logic [7:0] scratch_reg;
  logic [7:0] scratch_hi_reg;
  logic [7:0] rdata;

  // One write per strobe: take it on the strobe's first cycle
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      wr_act_d_reg <= 1'b0;
    else
      wr_act_d_reg <= wr_act;
  end
  assign wr_pulse = wr_act && !wr_act_d_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      cfg_reg <= CFG_RESET; // [RL11] [RL12]
    else if (wr_pulse && addr_eff == REG_CFG)
      cfg_reg <= BUS.d_in;
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scratch_reg <= 8'h00;
      scratch_hi_reg <= 8'h00;
    end else if (wr_pulse) begin
      if (addr_eff == REG_SCRATCH)
        scratch_reg <= BUS.d_in;
      if (addr_eff == REG_SCRATCH_HI)
        scratch_hi_reg <= BUS.d_in;
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      event_reg <= 8'h00;
    else if (wr_pulse && addr_eff == REG_EVENT)
      event_reg <= (event_reg & ~BUS.d_in) | USER_EVENT_SET;
    else
      event_reg <= event_reg | USER_EVENT_SET;
  end

  always_comb begin
    case (addr_eff)
      REG_CFG: rdata = cfg_reg;
      REG_STAT: rdata = {5'h00, dma_mode, mux_mode, BUS.mode};
      REG_EVENT: rdata = event_reg;
      REG_SCRATCH: rdata = scratch_reg;
      REG_SCRATCH_HI: rdata = scratch_hi_reg;
      default: rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Data bus drive
  // ****************************************************************
  logic [7:0] dout_reg;
  logic doe_n_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dout_reg <= 8'h00;
      doe_n_reg <= 1'b1;
    end else begin
      dout_reg <= rdata;
      doe_n_reg <= !rd_act; // [RL2] [RL8] [RL16]
    end
  end
  assign BUS.dev_d_out = dout_reg;
  assign BUS.dev_d_oe_n = doe_n_reg;

  // ****************************************************************
  // DMA requests and interrupt
  // ****************************************************************
  logic rx_act;
  logic tx_act;
  logic irq_act;
  logic rx_reg;
  logic tx_reg;
  logic irq_reg;
  logic irq_oe_n_reg;
  assign rx_act = dma_mode && event_reg[EV_RX];
  assign tx_act = dma_mode && event_reg[EV_TX];
  assign irq_act = cfg_reg[CFG_IRQ_EN] && event_reg[EV_IRQ]; // [RL14]

  // After reset both requests sit low; polarity bit high = active low
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_reg <= 1'b0;
      tx_reg <= 1'b0;
    end else begin
      rx_reg <= rx_act ^ cfg_reg[CFG_RX_POL]; // [RL11]
      tx_reg <= tx_act ^ cfg_reg[CFG_TX_POL]; // [RL12]
    end
  end
  assign BUS.dma_req_rx = rx_reg;
  assign BUS.dma_req_tx = tx_reg;

  // Open drain only ever pulls low, so shared lines stay safe
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_reg <= 1'b0;
      irq_oe_n_reg <= 1'b1; // [RL13]
    end else if (in_reset_reg || cfg_reg[CFG_IRQ_OD]) begin
      irq_reg <= 1'b0;
      irq_oe_n_reg <= in_reset_reg || !irq_act; // [RL13] [RL14]
    end else begin
      irq_reg <= irq_act ^ cfg_reg[CFG_IRQ_POL]; // [RL13] [RL14]
      irq_oe_n_reg <= 1'b0;
    end
  end
  assign BUS.irq_out = irq_reg;
  assign BUS.irq_out_oe_n = irq_oe_n_reg;

  assign USER_CFG = cfg_reg;
  assign USER_SCRATCH = scratch_reg;
endmodule : hbp_device
`default_nettype wire

// ==== design/hbp_host.sv ====
/*
  Host end of the parallel host bus port: runs one register access on the
  pins per command taken over an Avalon-MM slave with waitrequest.
  Assumes the device is out of reset before a command is issued.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  hbp_if.host BUS,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  import hbp_pkg::*;

  typedef enum logic [4:0] {
    HBP_IDLE = 5'h01, HBP_ADDR = 5'h02, HBP_LATCH = 5'h04,
    HBP_STROBE = 5'h08, HBP_END = 5'h10
  } hbp_state_t;

  hbp_state_t state_reg;
  logic [4:0] cmd_reg;
  logic [6:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [2:0] cnt_reg;
  logic busy;
  logic [31:0] rd_mux;
  logic [31:0] rd_reg;
  logic ack_reg;

  assign busy = state_reg != HBP_IDLE;

  // ****************************************************************
  // Avalon-MM slave: one cycle of wait, then answer
  // ****************************************************************
  always_comb begin
    case (AVS_ADDRESS)
      CT_CMD: rd_mux = {27'h0, cmd_reg};
      CT_ADDR: rd_mux = {25'h0, addr_reg};
      CT_WDATA: rd_mux = {24'h0, wdata_reg};
      CT_STAT: rd_mux = {22'h0, BUS.reset_indication, busy, rdata_reg};
      default: rd_mux = 32'h0;
    endcase
  end
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
  assign AVS_READDATA = rd_reg;

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
      rd_reg <= rd_mux;
    end
  end

  logic av_wr;
  assign av_wr = AVS_WRITE && ack_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_reg <= 7'h00;
      wdata_reg <= 8'h00;
    end else if (av_wr && AVS_ADDRESS == CT_ADDR) begin
      addr_reg <= AVS_WRITEDATA[6:0];
    end else if (av_wr && AVS_ADDRESS == CT_WDATA) begin
      wdata_reg <= AVS_WRITEDATA[7:0];
    end
  end

  // ****************************************************************
  // Pin sequencer
  // ****************************************************************
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= HBP_IDLE;
      cmd_reg <= 5'h00;
      cnt_reg <= 3'h0;
      rdata_reg <= 8'h00;
    end else begin
      case (state_reg)
        HBP_IDLE: begin
          // Commands while busy are dropped
          if (av_wr && AVS_ADDRESS == CT_CMD && AVS_WRITEDATA[CMD_GO]) begin
            cmd_reg <= AVS_WRITEDATA[4:0];
            state_reg <= HBP_ADDR;
          end
        end
        HBP_ADDR: state_reg <= HBP_LATCH;
        HBP_LATCH: begin
          cnt_reg <= 3'(STROBE_CYC);
          state_reg <= HBP_STROBE;
        end
        HBP_STROBE: begin
          if (cnt_reg == 3'h1) begin
            rdata_reg <= BUS.d_in; // [RL8]
            state_reg <= HBP_END;
          end
          cnt_reg <= cnt_reg - 3'h1;
        end
        HBP_END: state_reg <= HBP_IDLE;
        default: state_reg <= HBP_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  logic rd_cmd;
  logic mux_cmd;
  logic strobing;
  assign rd_cmd = cmd_reg[CMD_RD];
  assign mux_cmd = cmd_reg[CMD_MUX];
  assign strobing = state_reg == HBP_STROBE;

  assign BUS.cs_n = !(strobing || state_reg == HBP_LATCH); // [RL1]
  assign BUS.mode = cmd_reg[CMD_MOT]; // [RL6]
  // Demux keeps ALE high; mux pulses it during the address phase [RL5]
  assign BUS.ale = mux_cmd ? (state_reg == HBP_ADDR) : 1'b1; // [RL4]
  assign BUS.addr = addr_reg; // [RL9]
  // DMA acknowledge low when in DMA mode, else address bit 4 [RL10]
  assign BUS.dma_ack_in = cmd_reg[CMD_DMA] ? 1'b0 : addr_reg[4];
  assign BUS.irq_ack_in = 1'b0;
  // Separate strobes or direction plus data strobe [RL7] [RL8]
  assign BUS.rd_ds_n = cmd_reg[CMD_MOT] ? !strobing : !(strobing && rd_cmd);
  assign BUS.wr_rw = cmd_reg[CMD_MOT] ? rd_cmd : !(strobing && !rd_cmd);
  // Address phase then data phase on the shared lines [RL3]
  assign BUS.host_d_out = (mux_cmd && state_reg == HBP_ADDR) ?
                          {1'b0, addr_reg} : wdata_reg;
  assign BUS.host_d_oe_n = !((mux_cmd && state_reg == HBP_ADDR) ||
                             (!rd_cmd && (strobing || state_reg == HBP_LATCH)));
endmodule : hbp_host
`default_nettype wire

// ==== design/hbp_if.sv ====
/*
  Host bus port pins between the host controller and the device.
  Assumes the bench resolves the shared data and interrupt wires from
  the enables (enable low = driving).
*/
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
  logic cs_n;
  logic rd_ds_n;
  logic wr_rw;
  logic ale;
  logic mode;
  logic [6:0] addr;
  logic dma_ack_in;
  logic [7:0] host_d_out;
  logic host_d_oe_n;
  logic [7:0] dev_d_out;
  logic dev_d_oe_n;
  logic [7:0] d_in;
  logic dma_req_rx;
  logic dma_req_tx;
  logic irq_out;
  logic irq_out_oe_n;
  logic irq_in;
  logic irq_ack_in;
  logic reset_indication;

  modport dev (input cs_n, rd_ds_n, wr_rw, ale, mode, addr, dma_ack_in,
    d_in, irq_ack_in, output dev_d_out, dev_d_oe_n, dma_req_rx,
    dma_req_tx, irq_out, irq_out_oe_n, reset_indication);
  modport host (output cs_n, rd_ds_n, wr_rw, ale, mode, addr, dma_ack_in,
    host_d_out, host_d_oe_n, irq_ack_in, input d_in, dma_req_rx,
    dma_req_tx, irq_in, reset_indication);
endinterface : hbp_if
`default_nettype wire

// ==== design/hbp_pkg.sv ====
/*
  Shared constants for the parallel host bus port: register map of the
  device-side control block, field positions, reset values, timing counts.
  Assumes a 100 MHz core clock on both ends.
*/
package hbp_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_US = 500;
  localparam int RESET_HOLD_CYC = RESET_HOLD_US * 1000 / CLK_PERIOD_NS;

  // ****************************************************************
  // Device register map (7-bit addresses)
  // ****************************************************************
  localparam logic [6:0] REG_CFG = 7'h00;
  localparam logic [6:0] REG_STAT = 7'h01;
  localparam logic [6:0] REG_EVENT = 7'h02;
  localparam logic [6:0] REG_SCRATCH = 7'h03;
  localparam logic [6:0] REG_SCRATCH_HI = 7'h13;

  // CFG fields
  localparam int CFG_DMA_EN = 0;
  localparam int CFG_RX_POL = 1;
  localparam int CFG_TX_POL = 2;
  localparam int CFG_IRQ_OD = 3;
  localparam int CFG_IRQ_POL = 4;
  localparam int CFG_IRQ_EN = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // EVENT fields: device-side requests set by the user side
  localparam int EV_IRQ = 0;
  localparam int EV_RX = 1;
  localparam int EV_TX = 2;

  // ****************************************************************
  // Controller (Avalon-MM slave) map, byte addresses
  // ****************************************************************
  localparam logic [3:0] CT_CMD = 4'h0;
  localparam logic [3:0] CT_ADDR = 4'h4;
  localparam logic [3:0] CT_WDATA = 4'h8;
  localparam logic [3:0] CT_STAT = 4'hc;
  localparam int CMD_GO = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_MUX = 2;
  localparam int CMD_MOT = 3;
  localparam int CMD_DMA = 4;
  localparam int STROBE_CYC = 4;
endpackage : hbp_pkg

// ==== dv/hbp_chk.sv ====
/*
  Checker on the host bus port pins between host and device ends.
  Assumes the bench instantiates it beside the interface, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hbp_chk #(
  parameter int RESET_HOLD = hbp_pkg::RESET_HOLD_CYC
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic cs_n,
  input wire logic rd_ds_n,
  input wire logic wr_rw,
  input wire logic mode,
  input wire logic dev_d_oe_n,
  input wire logic dma_req_rx,
  input wire logic dma_req_tx,
  input wire logic irq_out_oe_n,
  input wire logic reset_indication
);
  // ****************************************************************
  // Device-side pin properties
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_rst_hold;
    $fell(SYS_RST) |-> reset_indication [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset indication dropped too early");
  // Counts the cycles the indication has stood since release
  logic [31:0] hold_cnt_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST)
      hold_cnt_reg <= 32'h0;
    else if (reset_indication)
      hold_cnt_reg <= hold_cnt_reg + 32'h1;
  end
  property p_rst_min;
    hold_cnt_reg < 32'(RESET_HOLD) |-> reset_indication;
  endproperty
  a_rst_min: assert property (p_rst_min)
    else $error("reset indication shorter than the hold time");
  property p_rx_rst;
    reset_indication |-> !dma_req_rx;
  endproperty
  a_rx_rst: assert property (p_rx_rst)
    else $error("receive request active in reset");
  property p_tx_rst;
    reset_indication |-> !dma_req_tx;
  endproperty
  a_tx_rst: assert property (p_tx_rst)
    else $error("transmit request active in reset");
  property p_irq_rst;
    reset_indication |-> irq_out_oe_n;
  endproperty
  a_irq_rst: assert property (p_irq_rst)
    else $error("interrupt pin driven in reset");
  property p_desel;
    cs_n && $past(cs_n) |-> dev_d_oe_n;
  endproperty
  a_desel: assert property (p_desel)
    else $error("data driven while deselected");
  property p_drv_sel;
    !dev_d_oe_n |-> $past(!cs_n);
  endproperty
  a_drv_sel: assert property (p_drv_sel)
    else $error("data driven without select");
  property p_drv_dir;
    !dev_d_oe_n |-> $past(!rd_ds_n && (wr_rw || !mode));
  endproperty
  a_drv_dir: assert property (p_drv_dir)
    else $error("data driven outside a read");
  // Two sampled read cycles give the device its one-cycle turn-on
  property p_rd_drv;
    !reset_indication && !cs_n && !rd_ds_n && (wr_rw || !mode) &&
      $past(!reset_indication && !cs_n && !rd_ds_n) |-> !dev_d_oe_n;
  endproperty
  a_rd_drv: assert property (p_rd_drv)
    else $error("data not driven during read");
endmodule : hbp_chk
`default_nettype wire

// ==== dv/hbp_tb.sv ====
/*
  Self-checking bench: host and device ends joined by the pin interface,
  driven through the host's Avalon-MM slave.
  Assumes the shared data and interrupt wires are resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_port_dma_irq_tb;
  import hbp_pkg::*;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [7:0] ev_set = 8'h00;
  logic [7:0] user_cfg;
  logic [7:0] user_scratch;
  logic flt = 1'b0;
  logic [7:0] rv;
  logic [7:0] irq_cfg [3] = '{8'h20, 8'h30, 8'h28};
  logic irq_on [3] = '{1'b1, 1'b0, 1'b0};
  int n_errors = 0;
  int num_checks = 0;
  int i;

  hbp_if bus_if ();
  // Released data wire toggles, so a stale byte never reads as good
  assign bus_if.d_in = !bus_if.dev_d_oe_n ? bus_if.dev_d_out :
    (!bus_if.host_d_oe_n ? bus_if.host_d_out : {8{flt}});
  // Pull-up on the shared interrupt wire
  assign bus_if.irq_in = bus_if.irq_out_oe_n ? 1'b1 : bus_if.irq_out;

  always #5 clk = ~clk;
  always @(posedge clk) flt <= ~flt;

  hbp_device #(.RESET_HOLD(HOLD)) hbp_device_inst (.CORE_CLK(clk),
    .SYS_RST(sys_rst), .BUS(bus_if), .USER_EVENT_SET(ev_set),
    .USER_CFG(user_cfg), .USER_SCRATCH(user_scratch));
  hbp_host hbp_host_inst (.CORE_CLK(clk), .SYS_RST(sys_rst), .BUS(bus_if),
    .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
    .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata),
    .AVS_WAITREQUEST(av_wait));
  hbp_chk #(.RESET_HOLD(HOLD)) hbp_chk_inst (.CORE_CLK(clk),
    .SYS_RST(sys_rst),
    .cs_n(bus_if.cs_n), .rd_ds_n(bus_if.rd_ds_n), .wr_rw(bus_if.wr_rw),
    .mode(bus_if.mode), .dev_d_oe_n(bus_if.dev_d_oe_n),
    .dma_req_rx(bus_if.dma_req_rx), .dma_req_tx(bus_if.dma_req_tx),
    .irq_out_oe_n(bus_if.irq_out_oe_n),
    .reset_indication(bus_if.reset_indication));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Called just after a rising edge; waitrequest and data taken at an edge
  task av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    int k;
    av_addr <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wdata <= wd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (av_wait !== 1'b0 && k < 100);
    if (av_wait !== 1'b0) begin
      n_errors++;
      stop_test();
    end
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask : av

  // One pin access; bm is {dma, strobe mode, multiplexed}
  task acc(input logic rd_op, input logic [2:0] bm, input logic [6:0] a,
      input logic [7:0] wd, output logic [7:0] rd);
    logic [31:0] r;
    int k;
    av(1'b1, CT_ADDR, {25'h0, a}, r);
    av(1'b1, CT_WDATA, {24'h0, wd}, r);
    av(1'b1, CT_CMD, {27'h0, bm, rd_op, 1'b1}, r);
    k = 0;
    do begin
      av(1'b0, CT_STAT, 32'h0, r);
      k++;
    end while (r[8] !== 1'b0 && k < 50);
    if (r[8] !== 1'b0) begin
      n_errors++;
      stop_test();
    end
    rd = r[7:0];
  endtask : acc

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    check(bus_if.reset_indication, 1'b1);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx}, 2'b00);
    check(bus_if.irq_in, 1'b1);
    sys_rst <= 1'b0;
    repeat (HOLD - 2) @(posedge clk);
    check(bus_if.reset_indication, 1'b1);
    i = 0;
    while (bus_if.reset_indication !== 1'b0 && i < 8) begin
      @(posedge clk);
      i++;
    end
    check(bus_if.reset_indication, 1'b0);
    for (int m = 0; m < 4; m++) begin
      acc(1'b0, {1'b0, m[1:0]}, REG_SCRATCH, 8'h5a + m[7:0], rv);
      acc(1'b1, {1'b0, m[1:0]}, REG_SCRATCH, 8'h00, rv);
      check(rv, 8'h5a + m[7:0]);
      check(user_scratch, 8'h5a + m[7:0]);
      acc(1'b1, {1'b0, m[1:0]}, REG_STAT, 8'h00, rv);
      check(rv, {6'h0, m[0], m[1]});
    end
    acc(1'b0, 3'b000, REG_SCRATCH_HI, 8'hc3, rv);
    acc(1'b0, 3'b000, REG_SCRATCH, 8'h3c, rv);
    acc(1'b1, 3'b000, REG_SCRATCH_HI, 8'h00, rv);
    check(rv, 8'hc3);
    acc(1'b0, 3'b000, REG_CFG, 8'h01, rv);
    acc(1'b1, 3'b100, REG_SCRATCH_HI, 8'h00, rv);
    check(rv, 8'h3c);
    // Shared pin high here: the device alone must force bit 4 low
    acc(1'b1, 3'b000, REG_SCRATCH_HI, 8'h00, rv);
    check(rv, 8'h3c);
    ev_set <= 8'h06;
    @(posedge clk);
    ev_set <= 8'h00;
    repeat (3) @(posedge clk);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx}, 2'b11);
    acc(1'b0, 3'b000, REG_CFG, 8'h07, rv);
    check(user_cfg, 8'h07);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx}, 2'b00);
    acc(1'b0, 3'b000, REG_EVENT, 8'h06, rv);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx}, 2'b11);
    for (int k = 0; k < 3; k++) begin
      acc(1'b0, 3'b000, REG_CFG, irq_cfg[k], rv);
      ev_set <= 8'h01;
      @(posedge clk);
      ev_set <= 8'h00;
      repeat (3) @(posedge clk);
      check(bus_if.irq_in, irq_on[k]);
      acc(1'b0, 3'b000, REG_EVENT, 8'h01, rv);
      check(bus_if.irq_in, !irq_on[k]);
    end
    // ****************************************************************
    // Mid-run reset with requests and interrupt driven
    // ****************************************************************
    acc(1'b0, 3'b000, REG_CFG, 8'h27, rv);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx, bus_if.irq_out_oe_n},
      3'b110);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx, bus_if.irq_out_oe_n},
      3'b001);
    sys_rst <= 1'b0;
    i = 0;
    while (bus_if.reset_indication !== 1'b0 && i < HOLD + 8) begin
      @(posedge clk);
      i++;
    end
    check(bus_if.reset_indication, 1'b0);
    check(i > HOLD, 1'b1);
    check({bus_if.dma_req_rx, bus_if.dma_req_tx, bus_if.irq_out_oe_n},
      3'b001);
    acc(1'b1, 3'b000, REG_CFG, 8'h00, rv);
    check(rv, CFG_RESET);
    stop_test();
  end
endmodule : host_bus_port_dma_irq_tb
`default_nettype wire
